// ### design/modbus_slave_pkg.sv
// constants, register map and state types of the modbus status and exception slave
package modbus_slave_pkg;
    // function and exception codes
    localparam logic [7:0] FUNC_READ_WORDS = 8'h03;
    localparam logic [7:0] EXC_FLAG = 8'h80;
    localparam logic [7:0] EXC_NONE = 8'h00;
    localparam logic [7:0] EXC_ILLEGAL_FUNC = 8'h01;
    localparam logic [7:0] EXC_ILLEGAL_ADDR = 8'h02;
    localparam logic [7:0] EXC_ILLEGAL_VALUE = 8'h03;
    localparam logic [7:0] EXC_DEVICE_FAIL = 8'h04;
    localparam logic [7:0] DISPLAY_TIMEOUT_CODE = 8'h10;
    localparam logic [15:0] MAX_READ_WORDS = 16'h0010;
    localparam logic [2:0] PROTOCOL_MAX = 3'h2;
    // register word addresses
    localparam logic [15:0] ADDR_DRIVE_STATUS = 16'h2101;
    localparam logic [15:0] ADDR_FREQ_COMMAND = 16'h2102;
    localparam logic [15:0] ADDR_OUTPUT_FREQ = 16'h2103;
    localparam logic [15:0] ADDR_OUTPUT_CURRENT = 16'h2104;
    localparam logic [15:0] ADDR_PID_FEEDBACK = 16'h2106;
    localparam logic [15:0] ADDR_DC_BUS_VOLTAGE = 16'h2108;
    localparam logic [15:0] ADDR_OUTPUT_VOLTAGE = 16'h2109;
    localparam logic [15:0] ADDR_STAGE_TEMP = 16'h210A;
    localparam logic [15:0] ADDR_USER_VALUE = 16'h2116;
    localparam logic [15:0] ADDR_USER_FORMAT = 16'h2117;
    // status word field positions
    localparam int STAT_DIR_LSB = 3;
    localparam int STAT_FREQ_COMM_BIT = 8;
    localparam int STAT_FREQ_ANALOG_BIT = 9;
    localparam int STAT_RUN_COMM_BIT = 10;
    // framing characters and check seeds
    localparam logic [7:0] ASCII_COLON = 8'h3A;
    localparam logic [7:0] ASCII_CR = 8'h0D;
    localparam logic [7:0] ASCII_LF = 8'h0A;
    localparam logic [7:0] ASCII_ZERO = 8'h30;
    localparam logic [7:0] ASCII_LETTER_BASE = 8'h37;
    localparam logic [15:0] CRC_INIT = 16'hFFFF;
    localparam logic [15:0] CRC_POLY = 16'hA001;
    // bus idle timeout unit
    localparam int CLK_PERIOD_NS = 5;
    localparam int TIMEOUT_UNIT_NS = 100000000;
    localparam int TIMEOUT_UNIT_CYCLES = TIMEOUT_UNIT_NS / CLK_PERIOD_NS;
    // state machines
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_SCAN = 3'b010,
        ST_SEND = 3'b100
    } req_state_t;
    typedef enum logic [6:0] {
        FB_WAIT = 7'b0000001,
        FB_HI = 7'b0000010,
        FB_LO = 7'b0000100,
        FB_CHKLO = 7'b0001000,
        FB_CHKHI = 7'b0010000,
        FB_CR = 7'b0100000,
        FB_LF = 7'b1000000
    } frame_state_t;
endpackage

// ### design/frame_builder.sv
// frame builder: wraps reply bytes in ascii or rtu framing with lrc or crc
`timescale 1ns/1ps
module frame_builder
    import modbus_slave_pkg::*;
(
    // clock, reset, enable and mode select
    input wire logic sysClk,
    input wire logic rst,
    input wire logic ce,
    input wire logic asciiMode,
    // reply bytes in
    input wire logic inValid,
    input wire logic [7:0] inData,
    input wire logic inLast,
    output logic inReady,
    // serial characters out
    output logic txValid_ff,
    output logic [7:0] txData_ff,
    input wire logic txReady
);
    frame_state_t state_ff;
    logic [7:0] curByte_ff;
    logic [15:0] crc_ff;
    logic [7:0] lrc_ff;
    logic last_ff;
    logic inChk_ff;
    logic sof_ff;
    logic [15:0] crcNew;
    logic [7:0] lrcNeg;
    logic txFree;
    logic take;

    // reflected crc update over one byte
    function automatic logic [15:0] crcStep(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c ^ {8'h00, b};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction

    // nibble to upper-case hex character
    function automatic logic [7:0] hexChar(input logic [3:0] n);
        return (n < 4'hA) ? (ASCII_ZERO + {4'h0, n}) : (ASCII_LETTER_BASE + {4'h0, n});
    endfunction

    // handshake terms
    assign txFree = !txValid_ff || txReady;
    assign inReady = (state_ff == FB_WAIT) && txFree;
    assign take = inReady && inValid;
    assign crcNew = crcStep(crc_ff, inData);
    assign lrcNeg = 8'h00 - lrc_ff;

    // character sequencer
    always_ff @(posedge sysClk) begin
        if (rst) begin
            state_ff <= FB_WAIT;
            curByte_ff <= 8'h00;
            crc_ff <= CRC_INIT;
            lrc_ff <= 8'h00;
            last_ff <= 1'b0;
            inChk_ff <= 1'b0;
            sof_ff <= 1'b1;
            txValid_ff <= 1'b0;
            txData_ff <= 8'h00;
        end else if (ce && txFree) begin
            txValid_ff <= 1'b1;
            case (state_ff)
                FB_WAIT: begin
                    txValid_ff <= take;
                    if (take) begin
                        curByte_ff <= inData;
                        last_ff <= inLast;
                        crc_ff <= crcNew;
                        lrc_ff <= lrc_ff + inData;
                        sof_ff <= 1'b0;
                        if (asciiMode && sof_ff) begin
                            txData_ff <= ASCII_COLON;
                            state_ff <= FB_HI;
                        end else if (asciiMode) begin
                            txData_ff <= hexChar(inData[7:4]);
                            state_ff <= FB_LO;
                        end else begin
                            txData_ff <= inData;
                            state_ff <= inLast ? FB_CHKLO : FB_WAIT;
                        end
                    end
                end
                FB_HI: begin
                    txData_ff <= hexChar(curByte_ff[7:4]);
                    state_ff <= FB_LO;
                end
                FB_LO: begin
                    txData_ff <= hexChar(curByte_ff[3:0]);
                    if (inChk_ff) begin
                        state_ff <= FB_CR;
                    end else if (last_ff) begin
                        curByte_ff <= lrcNeg;
                        inChk_ff <= 1'b1;
                        state_ff <= FB_HI;
                    end else begin
                        state_ff <= FB_WAIT;
                    end
                end
                FB_CHKLO: begin
                    txData_ff <= crc_ff[7:0];
                    state_ff <= FB_CHKHI;
                end
                FB_CHKHI: begin
                    txData_ff <= crc_ff[15:8];
                    crc_ff <= CRC_INIT;
                    lrc_ff <= 8'h00;
                    sof_ff <= 1'b1;
                    state_ff <= FB_WAIT;
                end
                FB_CR: begin
                    txData_ff <= ASCII_CR;
                    state_ff <= FB_LF;
                end
                default: begin
                    txData_ff <= ASCII_LF;
                    crc_ff <= CRC_INIT;
                    lrc_ff <= 8'h00;
                    inChk_ff <= 1'b0;
                    sof_ff <= 1'b1;
                    state_ff <= FB_WAIT;
                end
            endcase
        end
    end

    // ascii frame closes with cr then lf
    cr_then_lf_a: assert property (@(posedge sysClk) disable iff (rst)
        (ce && txFree && state_ff == FB_CR) |=> (txData_ff == ASCII_CR) && (state_ff == FB_LF))
        else $error("cr not followed by lf state");
endmodule // frame_builder

// ### design/modbus_status_and_exception_slave.sv
// modbus slave: read-only monitor map, exception replies and bus idle timeout
`timescale 1ns/1ps
// Function
// - direction field in status bits 3-4
// - bit 8: frequency set by serial link
// - bit 9: frequency set by analog input
// - bit 10: run commands from serial link
// - read-only monitor words at fixed addresses
// - user value word plus format word
// - corrupted message gets no reply at all
// - exception reply and decimal code on display
// - exception echoes function with top bit set
// - address, function, code, then lrc/crc
// - code 01 for unsupported function
// - code 02 for unmapped address
// - code 03 for unacceptable data value
// - code 04 when device cannot execute
module modbus_status_and_exception_slave
    import modbus_slave_pkg::*;
#(
    parameter int unsigned UNIT_CYCLES = TIMEOUT_UNIT_CYCLES
) (
    // clock, reset, enable
    input wire logic sysClk,
    input wire logic rst,
    input wire logic ce,
    // decoded request from receiver
    input wire logic reqValid,
    input wire logic reqError,
    input wire logic [7:0] reqSlaveAddr,
    input wire logic [7:0] reqFunc,
    input wire logic [15:0] reqAddr,
    input wire logic [15:0] reqCount,
    output logic reqReady_ff,
    // drive settings and state
    input wire logic asciiMode,
    input wire logic driveBusy,
    input wire logic busActivity,
    input wire logic [7:0] timeoutPeriodSetting,
    input wire logic [2:0] commFaultActionSetting,
    input wire logic [1:0] direction,
    input wire logic freqFromComm,
    input wire logic freqFromAnalog,
    input wire logic runFromComm,
    // monitor values
    input wire logic [15:0] frequencyCommand,
    input wire logic [15:0] outputFrequency,
    input wire logic [15:0] outputCurrent,
    input wire logic [15:0] pidFeedback,
    input wire logic [15:0] dcBusVoltage,
    input wire logic [15:0] outputVoltage,
    input wire logic [15:0] stageTemperature,
    input wire logic [15:0] userDisplayValue,
    input wire logic [7:0] userDecimalPlaces,
    input wire logic [7:0] userUnitLetter,
    // serial characters out
    output logic txValid_ff,
    output logic [7:0] txData_ff,
    input wire logic txReady,
    // front display
    output logic [7:0] exceptionDisplayCode_ff,
    output logic exceptionShow_ff,
    output logic busIdleTimeoutDisplay_ff
);
    req_state_t state_ff;
    req_state_t nxtState;
    logic [7:0] func_ff;
    logic [7:0] slave_ff;
    logic [15:0] addr_ff;
    logic [15:0] count_ff;
    logic [7:0] excCode_ff;
    logic [15:0] scanIdx_ff;
    logic [7:0] sendIdx_ff;
    logic [31:0] unitCnt_ff;
    logic [7:0] idleUnits_ff;
    logic [15:0] statusWord;
    logic [16:0] scanHit;
    logic [16:0] sendHit;
    logic [15:0] scanAddr;
    logic [15:0] sendAddr;
    logic [7:0] dataOff;
    logic [7:0] lastIdx;
    logic [7:0] sendByte;
    logic sendLast;
    logic sendValid;
    logic sendReady;
    logic accept;
    logic scanEnd;
    logic isExc;
    logic armed;
    logic unitTick;
    logic timeoutHit;

    // status word: reserved bits zero
    assign statusWord = {5'h00, runFromComm, freqFromAnalog, freqFromComm, 3'h0, direction, 3'h0};

    // map lookup: {valid, data}
    function automatic logic [16:0] mapRead(input logic [15:0] a);
        logic [16:0] r;
        r = 17'h00000;
        if (a == ADDR_DRIVE_STATUS) begin
            r = {1'b1, statusWord};
        end else if (a == ADDR_FREQ_COMMAND) begin
            r = {1'b1, frequencyCommand};
        end else if (a == ADDR_OUTPUT_FREQ) begin
            r = {1'b1, outputFrequency};
        end else if (a == ADDR_OUTPUT_CURRENT) begin
            r = {1'b1, outputCurrent};
        end else if (a == ADDR_PID_FEEDBACK) begin
            r = {1'b1, pidFeedback};
        end else if (a == ADDR_DC_BUS_VOLTAGE) begin
            r = {1'b1, dcBusVoltage};
        end else if (a == ADDR_OUTPUT_VOLTAGE) begin
            r = {1'b1, outputVoltage};
        end else if (a == ADDR_STAGE_TEMP) begin
            r = {1'b1, stageTemperature};
        end else if (a == ADDR_USER_VALUE) begin
            r = {1'b1, userDisplayValue};
        end else if (a == ADDR_USER_FORMAT) begin
            r = {1'b1, userDecimalPlaces, userUnitLetter};
        end
        return r;
    endfunction

    // address scan and reply byte selection
    assign scanAddr = addr_ff + scanIdx_ff;
    always_comb scanHit = mapRead(scanAddr);
    assign scanEnd = (scanIdx_ff == count_ff - 16'h0001);
    assign dataOff = sendIdx_ff - 8'h03;
    assign sendAddr = addr_ff + {9'h000, dataOff[7:1]};
    always_comb sendHit = mapRead(sendAddr);
    assign isExc = (excCode_ff != EXC_NONE);
    assign lastIdx = 8'h02 + {count_ff[6:0], 1'b0};
    assign sendLast = isExc ? (sendIdx_ff == 8'h02) : (sendIdx_ff == lastIdx);
    assign sendValid = (state_ff == ST_SEND);
    assign accept = reqValid && reqReady_ff && (state_ff == ST_IDLE);

    // reply byte: address, function, code or count, data words high first
    always_comb begin
        if (sendIdx_ff == 8'h00) begin
            sendByte = slave_ff;
        end else if (sendIdx_ff == 8'h01) begin
            sendByte = isExc ? (func_ff | EXC_FLAG) : func_ff;
        end else if (sendIdx_ff == 8'h02) begin
            sendByte = isExc ? excCode_ff : {count_ff[6:0], 1'b0};
        end else begin
            sendByte = dataOff[0] ? sendHit[7:0] : sendHit[15:8];
        end
    end

    // request state sequencing
    always_comb begin
        nxtState = state_ff;
        case (state_ff)
            ST_IDLE: begin
                if (accept && !reqError) begin
                    nxtState = (reqFunc == FUNC_READ_WORDS && reqCount != 16'h0000 && reqCount <= MAX_READ_WORDS)
                        ? ST_SCAN : ST_SEND;
                end
            end
            ST_SCAN: begin
                if (!scanHit[16] || scanEnd) begin
                    nxtState = ST_SEND;
                end
            end
            default: begin
                if (sendReady && sendLast) begin
                    nxtState = ST_IDLE;
                end
            end
        endcase
    end

    // state, request latch and exception choice
    always_ff @(posedge sysClk) begin
        if (rst) begin
            state_ff <= ST_IDLE;
            reqReady_ff <= 1'b0;
            func_ff <= 8'h00;
            slave_ff <= 8'h00;
            addr_ff <= 16'h0000;
            count_ff <= 16'h0000;
            excCode_ff <= EXC_NONE;
            scanIdx_ff <= 16'h0000;
            sendIdx_ff <= 8'h00;
        end else if (ce) begin
            state_ff <= nxtState;
            reqReady_ff <= (nxtState == ST_IDLE);
            if (accept) begin
                func_ff <= reqFunc;
                slave_ff <= reqSlaveAddr;
                addr_ff <= reqAddr;
                count_ff <= reqCount;
                scanIdx_ff <= 16'h0000;
                sendIdx_ff <= 8'h00;
                if (reqFunc != FUNC_READ_WORDS) begin
                    excCode_ff <= EXC_ILLEGAL_FUNC;
                end else if (reqCount == 16'h0000 || reqCount > MAX_READ_WORDS) begin
                    excCode_ff <= EXC_ILLEGAL_VALUE;
                end else begin
                    excCode_ff <= EXC_NONE;
                end
            end
            if (state_ff == ST_SCAN) begin
                scanIdx_ff <= scanIdx_ff + 16'h0001;
                if (!scanHit[16]) begin
                    excCode_ff <= EXC_ILLEGAL_ADDR;
                end else if (scanEnd && driveBusy) begin
                    excCode_ff <= EXC_DEVICE_FAIL;
                end
            end
            if (sendValid && sendReady) begin
                sendIdx_ff <= sendIdx_ff + 8'h01;
            end
        end
    end

    // exception code shown in decimal on the display
    always_ff @(posedge sysClk) begin
        if (rst) begin
            exceptionDisplayCode_ff <= 8'h00;
            exceptionShow_ff <= 1'b0;
        end else if (ce && sendValid && sendIdx_ff == 8'h00) begin
            exceptionDisplayCode_ff <= excCode_ff;
            exceptionShow_ff <= isExc;
        end
    end

    // idle timeout, armed by nonzero period and protocol 0..2
    assign armed = (timeoutPeriodSetting != 8'h00) && (commFaultActionSetting <= PROTOCOL_MAX);
    assign unitTick = (unitCnt_ff == UNIT_CYCLES - 1);
    assign timeoutHit = armed && (idleUnits_ff == timeoutPeriodSetting);

    // count idle units; traffic restarts the count
    always_ff @(posedge sysClk) begin
        if (rst) begin
            unitCnt_ff <= 32'h00000000;
            idleUnits_ff <= 8'h00;
            busIdleTimeoutDisplay_ff <= 1'b0;
        end else if (ce) begin
            unitCnt_ff <= (busActivity || unitTick) ? 32'h00000000 : unitCnt_ff + 32'h00000001;
            if (busActivity || !armed) begin
                idleUnits_ff <= 8'h00;
            end else if (unitTick && !timeoutHit) begin
                idleUnits_ff <= idleUnits_ff + 8'h01;
            end
            if (timeoutHit) begin
                busIdleTimeoutDisplay_ff <= 1'b1;
            end else if (busActivity) begin
                busIdleTimeoutDisplay_ff <= 1'b0;
            end
        end
    end

    // framing and check field generation
    frame_builder u_frame (
        .sysClk(sysClk),
        .rst(rst),
        .ce(ce),
        .asciiMode(asciiMode),
        .inValid(sendValid),
        .inData(sendByte),
        .inLast(sendLast),
        .inReady(sendReady),
        .txValid_ff(txValid_ff),
        .txData_ff(txData_ff),
        .txReady(txReady)
    );

    // checks on map, exceptions and timeout
    reserved_zero_a: assert property (@(posedge sysClk) disable iff (rst)
        (statusWord[7:5] == 3'h0) && (statusWord[15:11] == 5'h00)) else $error("reserved status bits set");
    direction_field_a: assert property (@(posedge sysClk) disable iff (rst)
        statusWord[STAT_DIR_LSB +: 2] == direction && mapRead(ADDR_DRIVE_STATUS) == {1'b1, statusWord})
        else $error("direction field mismatch");
    freq_comm_a: assert property (@(posedge sysClk) disable iff (rst)
        statusWord[STAT_FREQ_COMM_BIT] == freqFromComm) else $error("bit 8 wrong");
    freq_analog_a: assert property (@(posedge sysClk) disable iff (rst)
        statusWord[STAT_FREQ_ANALOG_BIT] == freqFromAnalog) else $error("bit 9 wrong");
    run_comm_a: assert property (@(posedge sysClk) disable iff (rst)
        statusWord[STAT_RUN_COMM_BIT] == runFromComm) else $error("bit 10 wrong");
    monitor_map_a: assert property (@(posedge sysClk) disable iff (rst)
        mapRead(ADDR_STAGE_TEMP) == {1'b1, stageTemperature} && mapRead(16'h2105) == 17'h00000)
        else $error("monitor map wrong");
    user_format_a: assert property (@(posedge sysClk) disable iff (rst)
        mapRead(ADDR_USER_FORMAT) == {1'b1, userDecimalPlaces, userUnitLetter}) else $error("user format wrong");
    error_silent_a: assert property (@(posedge sysClk) disable iff (rst)
        (ce && accept && reqError) |=> (state_ff == ST_IDLE) [*2]) else $error("corrupt request answered");
    bad_func_a: assert property (@(posedge sysClk) disable iff (rst)
        (ce && accept && !reqError && reqFunc != FUNC_READ_WORDS) |=> (excCode_ff == EXC_ILLEGAL_FUNC) && sendValid)
        else $error("code 01 not chosen");
    bad_count_a: assert property (@(posedge sysClk) disable iff (rst)
        (ce && accept && reqFunc == FUNC_READ_WORDS && reqCount == 16'h0000) |=> excCode_ff == EXC_ILLEGAL_VALUE)
        else $error("code 03 not chosen");
    bad_addr_a: assert property (@(posedge sysClk) disable iff (rst)
        (ce && state_ff == ST_SCAN && !scanHit[16]) |=> (excCode_ff == EXC_ILLEGAL_ADDR) && sendValid)
        else $error("code 02 not chosen");
    dev_fail_a: assert property (@(posedge sysClk) disable iff (rst)
        (ce && state_ff == ST_SCAN && scanHit[16] && scanEnd && driveBusy) |=> excCode_ff == EXC_DEVICE_FAIL)
        else $error("code 04 not chosen");
    exc_func_a: assert property (@(posedge sysClk) disable iff (rst)
        (sendValid && isExc && sendIdx_ff == 8'h01) |-> sendByte == (func_ff | EXC_FLAG)) else $error("flag missing");
    exc_display_a: assert property (@(posedge sysClk) disable iff (rst)
        (ce && sendValid && sendIdx_ff == 8'h00 && isExc) |=> exceptionShow_ff && exceptionDisplayCode_ff == excCode_ff)
        else $error("display code wrong");
    exc_length_a: assert property (@(posedge sysClk) disable iff (rst)
        (sendValid && isExc) |-> (sendLast == (sendIdx_ff == 8'h02))) else $error("exception frame length wrong");
    idle_fault_a: assert property (@(posedge sysClk) disable iff (rst)
        (ce && timeoutHit) |=> busIdleTimeoutDisplay_ff) else $error("timeout fault missed");
    cover_normal_c: cover property (@(posedge sysClk) sendValid && sendReady && sendLast && !isExc);
    cover_exception_c: cover property (@(posedge sysClk) sendValid && sendReady && sendLast && isExc);
    cover_timeout_c: cover property (@(posedge sysClk) $rose(busIdleTimeoutDisplay_ff));
endmodule // modbus_status_and_exception_slave

// ### verif/modbus_master_model.sv
// far-side model: paces the serial characters, prompt or stalling
`timescale 1ns/1ps
module modbus_master_model (
    // clock and pace select
    input wire logic sysClk,
    input wire logic slow,
    // accept strobe toward the slave
    output logic txReady
);
    // ready every cycle, or about one cycle in three when slow
    initial txReady = 1'b1;
    always @(negedge sysClk) txReady <= !slow || $urandom_range(2) == 0;
endmodule // modbus_master_model

// ### verif/modbus_status_and_exception_slave_tb.sv
// self-checking bench for the modbus status and exception slave
`timescale 1ns/1ps
module modbus_status_and_exception_slave_tb;
    import modbus_slave_pkg::*;
    logic sysClk = 0, rst = 1, ce = 1, reqValid = 0, reqError = 0, asciiMode = 0, driveBusy = 0, slow = 0;
    logic busActivity = 1, freqFromComm = 0, freqFromAnalog = 0, runFromComm = 0, txReady;
    logic [7:0] reqSlaveAddr = 0, reqFunc = 0, timeoutPeriodSetting = 0, userDecimalPlaces = 0, userUnitLetter = 0;
    logic [15:0] reqAddr = 0, reqCount = 0;
    logic [15:0] mon [8] = '{default: 0};
    logic [2:0] commFaultActionSetting = 0;
    logic [1:0] direction = 0;
    logic reqReady_ff, txValid_ff, exceptionShow_ff, busIdleTimeoutDisplay_ff;
    logic [7:0] txData_ff, exceptionDisplayCode_ff;
    logic [7:0] expQ [$];
    logic [39:0] tbl [10] = '{{8'h06, 16'h2101, 16'h1}, {8'h03, 16'h2101, 16'h0}, {8'h03, 16'h2101, 16'h11},
        {8'h03, 16'h2105, 16'h1}, {8'h03, 16'h2101, 16'hA}, {8'h03, 16'h2101, 16'h4}, {8'h03, 16'h2106, 16'h1},
        {8'h03, 16'h2108, 16'h3}, {8'h03, 16'h2116, 16'h2}, {8'h03, 16'h2102, 16'h2}};
    int mismatches = 0, num_checks = 0;

    modbus_status_and_exception_slave #(.UNIT_CYCLES(8)) dut (
        .sysClk, .rst, .ce, .reqValid, .reqError, .reqSlaveAddr, .reqFunc, .reqAddr, .reqCount, .reqReady_ff,
        .asciiMode, .driveBusy, .busActivity, .timeoutPeriodSetting, .commFaultActionSetting, .direction,
        .freqFromComm, .freqFromAnalog, .runFromComm, .frequencyCommand(mon[0]), .outputFrequency(mon[1]),
        .outputCurrent(mon[2]), .pidFeedback(mon[3]), .dcBusVoltage(mon[4]), .outputVoltage(mon[5]),
        .stageTemperature(mon[6]), .userDisplayValue(mon[7]), .userDecimalPlaces, .userUnitLetter,
        .txValid_ff, .txData_ff, .txReady, .exceptionDisplayCode_ff, .exceptionShow_ff, .busIdleTimeoutDisplay_ff);
    modbus_master_model partner (.sysClk, .slow, .txReady);

    // clock
    initial forever #2.5 sysClk = ~sysClk;

    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // bounded wait of one cycle, stands in for the master reply timeout
    task automatic waitN(input int k);
        if (k > 3000) begin
            mismatches++;
            $display("wrong value at %0t: wait ran out", $time);
            final_report();
        end
        @(negedge sysClk);
    endtask

    // register map as seen by the master
    function automatic logic [16:0] rd(input logic [15:0] a);
        case (a)
            ADDR_DRIVE_STATUS: return {6'h20, runFromComm, freqFromAnalog, freqFromComm, 3'h0, direction, 3'h0};
            ADDR_FREQ_COMMAND: return {1'b1, mon[0]};
            ADDR_OUTPUT_FREQ: return {1'b1, mon[1]};
            ADDR_OUTPUT_CURRENT: return {1'b1, mon[2]};
            ADDR_PID_FEEDBACK: return {1'b1, mon[3]};
            ADDR_DC_BUS_VOLTAGE: return {1'b1, mon[4]};
            ADDR_OUTPUT_VOLTAGE: return {1'b1, mon[5]};
            ADDR_STAGE_TEMP: return {1'b1, mon[6]};
            ADDR_USER_VALUE: return {1'b1, mon[7]};
            ADDR_USER_FORMAT: return {1'b1, userDecimalPlaces, userUnitLetter};
            default: return 17'h0;
        endcase
    endfunction

    function automatic logic [7:0] hx(input logic [3:0] n);
        return n < 4'hA ? ASCII_ZERO + 8'(n) : ASCII_LETTER_BASE + 8'(n);
    endfunction

    // issue one request and note the reply characters it must produce
    task automatic request(input logic [39:0] t, input logic err);
        logic [7:0] b [$];
        logic [7:0] f [$];
        logic [7:0] exc, s;
        logic [16:0] w;
        int k;
        {reqFunc, reqAddr, reqCount} = t;
        reqError = err;
        reqSlaveAddr = 8'($urandom);
        exc = EXC_NONE;
        b = {reqSlaveAddr, reqFunc, 8'(2 * reqCount)};
        for (k = 0; k < 16 && k < reqCount; k++) begin
            w = rd(reqAddr + 16'(k));
            if (!w[16]) exc = EXC_ILLEGAL_ADDR;
            b.push_back(w[15:8]);
            b.push_back(w[7:0]);
        end
        if (driveBusy && exc == EXC_NONE) exc = EXC_DEVICE_FAIL;
        if (reqCount == 0 || reqCount > MAX_READ_WORDS) exc = EXC_ILLEGAL_VALUE;
        if (reqFunc != FUNC_READ_WORDS) exc = EXC_ILLEGAL_FUNC;
        if (exc != EXC_NONE) b = {reqSlaveAddr, reqFunc | EXC_FLAG, exc};
        s = 8'h0;
        w = {1'b0, CRC_INIT};
        foreach (b[i]) begin
            s -= b[i];
            w[7:0] ^= b[i];
            repeat (8) w = w[0] ? {1'b0, w[15:1] ^ CRC_POLY} : {1'b0, w[15:1]};
        end
        if (asciiMode) begin
            b.push_back(s);
            f = {ASCII_COLON};
            foreach (b[i]) f = {f, hx(b[i][7:4]), hx(b[i][3:0])};
            f = {f, ASCII_CR, ASCII_LF};
        end else
            f = {b, w[7:0], w[15:8]};
        if (!err) expQ = f;
        for (k = 0; reqReady_ff !== 1'b1; k++) waitN(k);
        reqValid = 1;
        @(negedge sysClk);
        reqValid = 0;
        chk({7'h0, reqReady_ff}, {7'h0, err});
        for (k = 0; expQ.size() > 0; k++) waitN(k);
        repeat (20) @(negedge sysClk);
        if (!err) chk(exceptionDisplayCode_ff, exc);
        if (!err) chk({7'h0, exceptionShow_ff}, {7'h0, exc != EXC_NONE});
    endtask

    // compare each accepted reply character with the oldest note
    always @(posedge sysClk) begin
        if (txValid_ff === 1'b1 && txReady) chk(txData_ff, expQ.size() > 0 ? expQ.pop_front() : 8'hXX);
    end

    // main sequence
    initial begin
        void'($urandom(32'h703E));
        repeat (20) @(negedge sysClk);
        rst = 0;
        for (int m = 0; m < 2; m++) begin
            asciiMode = m[0];
            slow = m[0];
            for (int i = 0; i < 10; i++) begin
                foreach (mon[j]) mon[j] = 16'($urandom);
                {direction, freqFromComm, freqFromAnalog, runFromComm, userDecimalPlaces, userUnitLetter} = 21'($urandom);
                driveBusy = i == 9;
                request(tbl[i], 1'b0);
            end
            request(tbl[5], 1'b1);
            $display("test frames mode %0d done", m);
        end
        timeoutPeriodSetting = 8'h02;
        commFaultActionSetting = 3'h1;
        busActivity = 0;
        repeat (12) @(negedge sysClk);
        chk({7'h0, busIdleTimeoutDisplay_ff}, 8'h00);
        repeat (10) @(negedge sysClk);
        chk({7'h0, busIdleTimeoutDisplay_ff}, 8'h01);
        busActivity = 1;
        @(negedge sysClk);
        chk({7'h0, busIdleTimeoutDisplay_ff}, 8'h01);
        @(negedge sysClk);
        busActivity = 0;
        @(negedge sysClk);
        chk({7'h0, busIdleTimeoutDisplay_ff}, 8'h00);
        commFaultActionSetting = 3'h3;
        repeat (30) @(negedge sysClk);
        chk({7'h0, busIdleTimeoutDisplay_ff}, 8'h00);
        $display("test idle timeout done");
        final_report();
    end
endmodule // modbus_status_and_exception_slave_tb
